// ### rtl/ntbp_pkg.sv
/*
 * constants for the punch-through status and mapping table block.
 * assumes dword-aligned configuration offsets with 4 byte enables.
 */
package ntbp_pkg;
    localparam int unsigned addr_w = 12;
    localparam logic [11:0] off_status = 12'h00a8;
    localparam logic [11:0] off_pointer = 12'h00ac;
    localparam logic [11:0] off_entry = 12'h00b0;

    localparam int unsigned busy_pos = 0;
    localparam int unsigned done_pos = 1;
    localparam int unsigned cpl_lo = 2;
    localparam int unsigned cpl_hi = 4;
    localparam int unsigned abort_pos = 5;
    localparam int unsigned cap_pos = 31;

    localparam int unsigned ptr_lo = 2;
    localparam int unsigned ptr_hi = 5;
    localparam int unsigned ptr_w = 4;
    localparam int unsigned map_depth = 16;

    localparam int unsigned valid_pos = 0;
    localparam int unsigned requester_function_field_lo = 16;
    localparam int unsigned requester_function_field_hi = 18;
    localparam int unsigned dev_lo = 19;
    localparam int unsigned dev_hi = 23;
    localparam int unsigned bus_lo = 24;
    localparam int unsigned bus_hi = 31;
    localparam int unsigned entry_w = 17;

    localparam logic [3:0] be_full = 4'hf;
    localparam logic [31:0] word_zero = 32'h0000_0000;

    typedef enum logic [2:0] {
        cpl_success = 3'h0,
        cpl_unsupported = 3'h1,
        cpl_retry = 3'h2,
        cpl_completer_abort = 3'h3,
        cpl_requester_abort = 3'h4
    } ntbp_cpl_e;
endpackage

// ### rtl/ntbp_map_if.sv
/*
 * carrier between the register logic and the mapping table storage.
 * assumes one clock shared by both ends.
 */
interface ntbp_map_if;
    logic [3:0] sel;
    logic wr_en;
    logic [16:0] wdata;
    logic [16:0] rdata;
    modport regs (output sel, output wr_en, output wdata, input rdata);
    modport table_end (input sel, input wr_en, input wdata, output rdata);
endinterface

// ### rtl/ntbp_map_table.sv
/*
 * sixteen-entry requester-id mapping table.
 * assumes por_rst is the only reset that clears the entries.
 */
module ntbp_map_table (
    // clock and power-on reset
    input wire logic sys_clk,
    input wire logic por_rst,
    // access port
    ntbp_map_if.table_end map
);
    logic [ntbp_pkg::entry_w-1:0] entries [ntbp_pkg::map_depth];

    assign map.rdata = entries[map.sel]; // [R10]

    // survives srst, cleared at power-on only
    always_ff @(posedge sys_clk) begin
        if (por_rst) begin
            for (int i = 0; i < ntbp_pkg::map_depth; i++) begin
                entries[i] <= '0; // [R8]
            end
        end else if (map.wr_en) begin
            entries[map.sel] <= map.wdata; // [R10] [R17]
        end
    end
endmodule // ntbp_map_table

// ### rtl/ntbp_status_map.sv
/*
 * punch-through status register and mapping table window.
 * assumes configuration requests arrive as one-cycle strobes on sys_clk and
 * the far-side engine answers with a one-cycle completion strobe.
 */
// Contract
// [R1] busy bit high while transaction outstanding
// [R2] done set on completion, status valid
// [R3] write one clears done, aborts in-flight
// [R4] completion status encoding at bits 4:2
// [R5] software trusts status only while done
// [R6] abort bit set on requester abort
// [R7] capability bit; zero hides other fields
// [R8] done, pointer, table survive hot resets
// [R9] four-bit pointer field at bits 5:2
// [R10] data reads/writes selected table entry
// [R11] partial data access gets unsupported request
// [R12] entry fields function, device, bus layout
// [R13] entry bit 0 is valid flag
// [R14] data write launches far transaction, byte enables
// [R15] operation bit picks write or read
// [R16] busy clears on done or abort
// [R17] sixteen table entries
module ntbp_status_map #(
    parameter bit PUNCH_CAPABLE = 1'b1
) (
    // clock and resets
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic por_rst,
    // configuration request from the host
    input wire logic cfg_req_valid,
    input wire logic cfg_req_write,
    input wire logic [11:0] cfg_req_addr,
    input wire logic [3:0] cfg_req_be,
    input wire logic [31:0] cfg_req_wdata,
    // configuration completion to the host
    output logic cfg_cpl_valid,
    output logic cfg_cpl_ur,
    output logic [31:0] cfg_cpl_rdata,
    // launch from the punch data register write
    input wire logic punch_data_write,
    input wire logic [3:0] punch_data_be,
    input wire logic operation_select_bit,
    // far-side configuration engine
    output logic far_req_valid,
    output logic far_req_write,
    output logic [3:0] far_req_be,
    output logic far_abort,
    input wire logic far_cpl_valid,
    input wire logic [2:0] far_cpl_status,
    // status view
    output logic punch_busy
);
    ntbp_map_if map ();

    logic busy;
    logic done;
    logic [2:0] cpl_status;
    logic abort_status_bit;
    logic [ntbp_pkg::ptr_w-1:0] map_table_pointer;

    ntbp_map_table u_table (
        .sys_clk(sys_clk),
        .por_rst(por_rst),
        .map(map)
    );

    ////////////////////////////////////////////////////////////////////////
    // decode

    // one dword register matched by a valid request
    function automatic logic addr_hit(
        input logic valid,
        input logic [11:0] addr,
        input logic [11:0] offset
    );
        return valid && addr == offset;
    endfunction

    wire hit_status = addr_hit(cfg_req_valid, cfg_req_addr, ntbp_pkg::off_status);
    wire hit_pointer = addr_hit(cfg_req_valid, cfg_req_addr, ntbp_pkg::off_pointer);
    wire hit_entry = addr_hit(cfg_req_valid, cfg_req_addr, ntbp_pkg::off_entry);
    wire entry_partial = hit_entry && cfg_req_be != ntbp_pkg::be_full; // [R11]
    wire wr_status = hit_status && cfg_req_write;
    wire wr_pointer = hit_pointer && cfg_req_write;
    wire wr_entry = hit_entry && cfg_req_write;
    wire done_bit_one = cfg_req_wdata[ntbp_pkg::done_pos];
    wire done_w1c = wr_status && cfg_req_be[0] && done_bit_one; // [R3]
    wire ptr_write = wr_pointer && cfg_req_be[0]; // [R9]
    wire [ntbp_pkg::ptr_w-1:0] ptr_field = cfg_req_wdata[ntbp_pkg::ptr_hi:ntbp_pkg::ptr_lo];

    ////////////////////////////////////////////////////////////////////////
    // punch-through events

    // capability strap gates every punch event
    wire cap = PUNCH_CAPABLE;
    wire launch = cap && punch_data_write && !busy; // [R14]
    wire abort_now = done_w1c && busy && cap; // [R3]
    wire far_done = cap && busy && far_cpl_valid;

    ////////////////////////////////////////////////////////////////////////
    // table carrier

    assign map.sel = map_table_pointer;
    assign map.wr_en = wr_entry && !entry_partial; // [R10] [R11]
    assign map.wdata = {cfg_req_wdata[ntbp_pkg::bus_hi:ntbp_pkg::requester_function_field_lo],
                        cfg_req_wdata[ntbp_pkg::valid_pos]}; // [R12] [R13]

    ////////////////////////////////////////////////////////////////////////
    // read data

    wire [31:0] status_raw = {1'b1, 25'h000_0000, abort_status_bit, cpl_status,
                              done, busy}; // [R4]
    wire [31:0] status_word;
    // capability strap low hides every status field
    for (genvar b = 0; b < 32; b++) begin : g_cap_mask
        assign status_word[b] = status_raw[b] && cap; // [R7]
    end
    wire [31:0] entry_word = {map.rdata[ntbp_pkg::entry_w-1:1], 15'h0000,
                              map.rdata[ntbp_pkg::valid_pos]}; // [R12] [R13]
    wire [31:0] pointer_word = {26'h000_0000, map_table_pointer, 2'h0}; // [R9]
    // writes, refused and unmapped requests read back zero
    wire no_data = cfg_req_write || entry_partial;
    wire [31:0] next_rdata = no_data ? ntbp_pkg::word_zero :
                             hit_status ? status_word :
                             hit_pointer ? pointer_word :
                             hit_entry ? entry_word : ntbp_pkg::word_zero;

    ////////////////////////////////////////////////////////////////////////
    // completion to the host

    wire next_cpl_valid = cfg_req_valid;
    wire next_cpl_ur = entry_partial; // [R11]

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cfg_cpl_valid <= 1'b0;
            cfg_cpl_ur <= 1'b0;
            cfg_cpl_rdata <= '0;
        end else begin
            cfg_cpl_valid <= next_cpl_valid;
            cfg_cpl_ur <= next_cpl_ur; // [R11]
            cfg_cpl_rdata <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // punch-through status, cleared by srst

    // launch wins over a stale completion or abort
    wire next_busy = launch ? 1'b1 : (far_done || abort_now) ? 1'b0 : busy; // [R1] [R16]
    wire next_abort_status_bit = launch ? 1'b0 :
                                 far_done ? far_cpl_status == ntbp_pkg::cpl_requester_abort :
                                 abort_status_bit; // [R6]

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            busy <= 1'b0;
        end else begin
            busy <= next_busy; // [R1]
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cpl_status <= ntbp_pkg::cpl_success;
        end else if (far_done) begin
            cpl_status <= far_cpl_status; // [R2] [R4]
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            abort_status_bit <= 1'b0;
        end else begin
            abort_status_bit <= next_abort_status_bit; // [R6]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // survives srst

    // completion beats a clear in the same cycle
    wire next_done = far_done ? 1'b1 : (done_w1c || launch) ? 1'b0 : done; // [R2] [R3]

    always_ff @(posedge sys_clk) begin
        if (por_rst) begin
            done <= 1'b0;
        end else begin
            done <= next_done; // [R8]
        end
    end

    always_ff @(posedge sys_clk) begin
        if (por_rst) begin
            map_table_pointer <= '0;
        end else if (ptr_write) begin
            map_table_pointer <= ptr_field; // [R8] [R9]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // far-side request strobes

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            far_req_valid <= 1'b0;
            far_abort <= 1'b0;
            punch_busy <= 1'b0;
        end else begin
            far_req_valid <= launch; // [R14]
            far_abort <= abort_now; // [R3]
            punch_busy <= next_busy; // [R1]
        end
    end

    // operation and byte enables held from launch to launch
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            far_req_write <= 1'b0;
            far_req_be <= '0;
        end else if (launch) begin
            far_req_write <= operation_select_bit; // [R15]
            far_req_be <= punch_data_be; // [R14]
        end
    end
endmodule // ntbp_status_map

// ### dv/ntbp_status_map_monitor.sv
/* status and table window assertions.
 * assumes a bind onto ntbp_status_map. */
module ntbp_status_map_monitor (
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // host side
    input wire logic cfg_req_valid,
    input wire logic cfg_req_write,
    input wire logic [11:0] cfg_req_addr,
    input wire logic [3:0] cfg_req_be,
    input wire logic [31:0] cfg_req_wdata,
    input wire logic cfg_cpl_valid,
    input wire logic cfg_cpl_ur,
    input wire logic [31:0] cfg_cpl_rdata,
    // punch side
    input wire logic punch_data_write,
    input wire logic [3:0] punch_data_be,
    input wire logic operation_select_bit,
    input wire logic far_req_valid,
    input wire logic far_req_write,
    input wire logic [3:0] far_req_be,
    input wire logic far_abort,
    input wire logic far_cpl_valid,
    input wire logic punch_busy
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    wire sts_hit = cfg_req_valid && cfg_req_addr == ntbp_pkg::off_status;
    wire w1c = sts_hit && cfg_req_write && cfg_req_be[0] && cfg_req_wdata[1];
    sequence s_launch; punch_data_write && !punch_busy; endsequence
    sequence s_go; far_req_valid && punch_busy; endsequence
    a_cpl_next: assert property (cfg_req_valid |=> cfg_cpl_valid)
        else $error("no completion");
    a_launch_busy: assert property (s_launch |=> s_go)
        else $error("launch lost");
    a_req_copy: assert property (far_req_valid |-> far_req_be == $past(punch_data_be)
        && far_req_write == $past(operation_select_bit)) else $error("launch fields");
    a_busy_hold: assert property (punch_busy && !far_cpl_valid && !w1c |=> punch_busy)
        else $error("busy dropped");
    a_busy_clear: assert property (punch_busy && (far_cpl_valid || w1c) |=> !punch_busy)
        else $error("busy stuck");
    a_abort_w1c: assert property (punch_busy && w1c && !far_cpl_valid |=> far_abort)
        else $error("no abort");
    a_part_ur: assert property (cfg_req_valid && cfg_req_addr == ntbp_pkg::off_entry
        && cfg_req_be != 4'hf |=> cfg_cpl_ur && cfg_cpl_rdata == 32'h0) else $error("partial");
    a_sts_view: assert property (sts_hit && !cfg_req_write |=> cfg_cpl_rdata[31]
        && cfg_cpl_rdata[0] == $past(punch_busy)) else $error("status view");
    a_abort_bit: assert property (sts_hit && !cfg_req_write |=> !cfg_cpl_rdata[1]
        || cfg_cpl_rdata[5] == (cfg_cpl_rdata[4:2] == 3'h4)) else $error("abort bit");
endmodule // ntbp_status_map_monitor
bind ntbp_status_map ntbp_status_map_monitor mon (.*);

// ### dv/ntbp_far_model.sv
/* far-side configuration engine.
 * assumes launches come only while idle. */
module ntbp_far_model (
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // launch and answer shape
    input wire logic far_req_valid,
    input wire logic far_abort,
    input wire logic [3:0] lat,
    input wire logic [2:0] code,
    // completion
    output logic far_cpl_valid,
    output logic [2:0] far_cpl_status
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [4:0] cnt;
    always_ff @(posedge sys_clk) begin
        far_cpl_valid <= cnt == 5'h01;
        far_cpl_status <= (cnt == 5'h01) ? code : ~code;
        if (srst || far_abort)
            cnt <= 5'h00;
        else if (far_req_valid)
            cnt <= {1'b0, lat} + 5'h01;
        else if (cnt != 5'h00)
            cnt <= cnt - 5'h01;
    end
endmodule // ntbp_far_model

// ### dv/ntbp_status_map_test.sv
/* bench for ntbp_status_map.
 * assumes the monitor bind and the far model. */
module ntbp_status_map_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [11:0] st = 12'h0a8, pt = 12'h0ac, en = 12'h0b0;
    logic sys_clk = 0, srst = 1, por_rst = 1, cfg_req_valid = 0, cfg_req_write = 0;
    logic punch_data_write = 0, operation_select_bit = 0, ur;
    logic [11:0] cfg_req_addr = 0;
    logic [3:0] cfg_req_be = 0, punch_data_be = 0, lat = 0, far_req_be;
    logic [31:0] cfg_req_wdata = 0, rd, w, cfg_cpl_rdata, tab [16];
    logic [2:0] code = 0, far_cpl_status;
    logic cfg_cpl_valid, cfg_cpl_ur, far_req_valid, far_req_write, far_abort;
    logic far_cpl_valid, punch_busy;
    int failures = 0, tests_run = 0, seed = 32'h6728a324, i;
    ntbp_status_map dut (.*);
    ntbp_far_model far (.*);
    always #10 sys_clk = ~sys_clk;
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cfg(logic wr, logic [11:0] a, logic [3:0] be, logic [31:0] d);
        @(posedge sys_clk) #1;
        {cfg_req_valid, cfg_req_write, cfg_req_addr} = {1'b1, wr, a};
        {cfg_req_be, cfg_req_wdata} = {be, d};
        @(posedge sys_clk) #1;
        cfg_req_valid = 0;
        chk(cfg_cpl_valid, 1);
        {ur, rd} = {cfg_cpl_ur, cfg_cpl_rdata};
    endtask
    task automatic launch(logic [3:0] be, bit poll);
        @(posedge sys_clk) #1;
        {punch_data_write, punch_data_be, operation_select_bit} = {1'b1, be, be[0]};
        @(posedge sys_clk) #1;
        punch_data_write = 0;
        chk({punch_busy, far_req_valid}, 2'b11);
        chk({far_req_write, far_req_be}, {be[0], be});
        cfg(0, st, 4'hf, 0);
        chk({rd[5], rd[1:0]}, 3'b001);
        for (int k = 0; k < 12 && poll && !rd[1]; k++) cfg(0, st, 4'hf, 0);
    endtask
    function automatic logic [31:0] sts(logic [2:0] c);
        return 32'h8000_0002 | {26'h0, c == 3'h4, c, 2'h0};
    endfunction
    task automatic final_report;
        if (failures == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge sys_clk);
        #1 {srst, por_rst} = 2'b00;
        cfg(0, st, 4'hf, 0);
        chk(rd, 32'h8000_0000);
        for (i = 0; i < 16; i++) begin
            w = $random(seed);
            tab[i] = w & 32'hffff_0001;
            cfg(1, pt, 4'hf, {w[31:6], i[3:0], w[1:0]});
            cfg(1, en, 4'hf, w);
        end
        for (i = 0; i < 16; i++) begin
            cfg(1, pt, 4'hf, i << 2);
            cfg(0, en, 4'hf, 0);
            chk(rd, tab[i]);
        end
        cfg(0, pt, 4'hf, 0);
        chk(rd, 32'h0000_003c);
        cfg(1, en, 4'h7, 0);
        chk(ur, 1);
        cfg(0, en, 4'h3, 0);
        chk({ur, rd[30:0]}, 32'h8000_0000);
        cfg(0, en, 4'hf, 0);
        chk({ur, rd}, {1'b0, tab[15]});
        cfg(0, 12'h0b4, 4'hf, 0);
        chk({ur, rd[30:0]}, 0);
        for (i = 0; i < 5; i++) begin
            w = $random(seed);
            {lat, code} = {2'b01, w[1:0], 3'(4 - i)};
            launch(w[7:4], 1);
            chk(rd, sts(code));
            cfg(1, st, 4'hf, 32'h0000_0002);
            cfg(0, st, 4'hf, 0);
            chk(rd & 32'hffff_ffe3, sts(code) & 32'hffff_ffe1);
        end
        launch(4'hf, 1);
        @(posedge sys_clk) #1 srst = 1;
        @(posedge sys_clk) #1 srst = 0;
        cfg(0, st, 4'hf, 0);
        chk(rd & 32'hffff_ffe3, 32'h8000_0002);
        cfg(0, en, 4'hf, 0);
        chk(rd, tab[15]);
        lat = 4'hf;
        launch(4'h5, 0);
        cfg(1, st, 4'hf, 32'h0000_0002);
        chk({far_abort, punch_busy}, 2'b10);
        repeat (20) @(posedge sys_clk);
        cfg(0, st, 4'hf, 0);
        chk(rd[1:0], 0);
        final_report;
    end
    initial begin
        #100000;
        failures++;
        final_report;
    end
endmodule // ntbp_status_map_test
